// file: rtl/bmx_pkg.sv
package bmx_pkg;
    localparam int PC_W = 16;
    localparam int DW   = 8;
    localparam int NEED_N   = 4;
    localparam int NEED_SP  = 0;
    localparam int NEED_SRC = 1;
    localparam int NEED_DP  = 2;
    localparam int NEED_BIT = 3;

    localparam logic [15:0] PC_RST  = 16'h0000;
    localparam logic [15:0] PC_STEP = 16'h0001;
    localparam logic [7:0]  SP_RST  = 8'h07;
    localparam logic [7:0]  SP_STEP = 8'h01;
    localparam logic [7:0]  ACC_RST = 8'h00;
    localparam logic [7:0]  ACC_DIR = 8'he0;
    localparam logic [7:0]  ACC_PAD = 8'h00;
    localparam logic [7:0]  BYTE_0  = 8'h00;
    localparam logic [2:0]  RN_PAGE = 3'h0;
    localparam logic [1:0]  RI_PAD  = 2'h0;
    localparam logic [1:0]  LEN_1   = 2'h1;
    localparam logic [1:0]  LEN_2   = 2'h2;
    localparam logic [1:0]  LEN_3   = 2'h3;
    localparam logic [1:0]  CYC_1   = 2'h1;
    localparam logic [1:0]  CYC_2   = 2'h2;
    localparam logic [1:0]  IX_OP   = 2'h0;
    localparam logic [1:0]  IX_B1   = 2'h1;
    localparam logic [1:0]  IX_B2   = 2'h2;
    localparam logic [1:0]  IX_STEP = 2'h1;

    localparam logic [7:0] OPC_JMP     = 8'h73;
    localparam logic [7:0] OPC_JNB     = 8'h30;
    localparam logic [7:0] OPC_JNC     = 8'h50;
    localparam logic [7:0] OPC_JNZ     = 8'h70;
    localparam logic [7:0] OPC_JZ      = 8'h60;
    localparam logic [7:0] OPC_LONG_CALL   = 8'h12;
    localparam logic [7:0] OPC_LONG_JUMP    = 8'h02;
    localparam logic [7:0] OPC_A_DIR   = 8'he5;
    localparam logic [7:0] OPC_A_IMM   = 8'h74;
    localparam logic [7:0] OPC_DIR_A   = 8'hf5;
    localparam logic [7:0] OPC_DIR_DIR = 8'h85;
    localparam logic [7:0] OPC_DIR_IMM = 8'h75;
    localparam logic [4:0] MV_A_RN     = 5'h1d;
    localparam logic [4:0] MV_RN_A     = 5'h1f;
    localparam logic [4:0] MV_RN_DIR   = 5'h15;
    localparam logic [4:0] MV_RN_IMM   = 5'h0f;
    localparam logic [4:0] MV_DIR_RN   = 5'h11;
    localparam logic [6:0] MV_A_IND    = 7'h73;
    localparam logic [6:0] MV_DIR_IND  = 7'h43;
    localparam logic [6:0] MV_IND_A    = 7'h7b;
    localparam logic [6:0] MV_IND_DIR  = 7'h53;
    localparam logic [6:0] MV_IND_IMM  = 7'h3b;

    typedef enum logic [3:0] {
        BMX_OP_NONE, BMX_OP_MOVE, BMX_OP_JMP, BMX_OP_JNB, BMX_OP_JNC,
        BMX_OP_JNZ, BMX_OP_JZ, BMX_OP_LONG_CALL, BMX_OP_LONG_JUMP
    } bmx_op_e;

    typedef enum logic [2:0] {
        BMX_LOC_A, BMX_LOC_RN, BMX_LOC_DIR, BMX_LOC_IND, BMX_LOC_IMM
    } bmx_loc_e;
endpackage

// file: rtl/bmx_decode.sv
`timescale 1ns/100ps
module bmx_decode (
    // opcode byte
    input  wire logic [bmx_pkg::DW-1:0] opc,
    // decoded form
    output bmx_pkg::bmx_op_e            op,
    output bmx_pkg::bmx_loc_e           src,
    output bmx_pkg::bmx_loc_e           dst,
    output logic                        src_b2,
    output logic                        dst_b2,
    output logic [1:0]                  len,
    output logic [1:0]                  cyc
);
    import bmx_pkg::*;

    wire m_a_rn   = opc[7:3] == MV_A_RN;
    wire m_a_dir  = opc == OPC_A_DIR;
    wire m_a_ind  = opc[7:1] == MV_A_IND;
    wire m_a_imm  = opc == OPC_A_IMM;
    wire m_rn_a   = opc[7:3] == MV_RN_A;
    wire m_rn_dir = opc[7:3] == MV_RN_DIR;
    wire m_rn_imm = opc[7:3] == MV_RN_IMM;
    wire m_dr_a   = opc == OPC_DIR_A;
    wire m_dr_rn  = opc[7:3] == MV_DIR_RN;
    wire m_dr_dr  = opc == OPC_DIR_DIR;
    wire m_dr_ind = opc[7:1] == MV_DIR_IND;
    wire m_dr_imm = opc == OPC_DIR_IMM;
    wire m_in_a   = opc[7:1] == MV_IND_A;
    wire m_in_dir = opc[7:1] == MV_IND_DIR;
    wire m_in_imm = opc[7:1] == MV_IND_IMM;

    // fifteen move forms by destination
    wire to_a  = m_a_rn | m_a_dir | m_a_ind | m_a_imm;
    wire to_rn = m_rn_a | m_rn_dir | m_rn_imm;
    wire to_dr = m_dr_a | m_dr_rn | m_dr_dr | m_dr_ind | m_dr_imm;
    wire to_in = m_in_a | m_in_dir | m_in_imm;
    wire mv    = to_a | to_rn | to_dr | to_in;
    wire fr_rn = m_a_rn | m_dr_rn;
    wire fr_dr = m_a_dir | m_rn_dir | m_dr_dr | m_in_dir;
    wire fr_in = m_a_ind | m_dr_ind;
    wire fr_im = m_a_imm | m_rn_imm | m_dr_imm | m_in_imm;

    wire j_ind = opc == OPC_JMP;
    wire j_nb  = opc == OPC_JNB;
    wire j_nc  = opc == OPC_JNC;
    wire j_nz  = opc == OPC_JNZ;
    wire j_z   = opc == OPC_JZ;
    wire j_cl  = opc == OPC_LONG_CALL;
    wire j_lj  = opc == OPC_LONG_JUMP;
    wire known = mv | j_ind | j_nb | j_nc | j_nz | j_z | j_cl | j_lj;

    assign op = mv    ? BMX_OP_MOVE  :
                j_ind ? BMX_OP_JMP   :
                j_nb  ? BMX_OP_JNB   :
                j_nc  ? BMX_OP_JNC   :
                j_nz  ? BMX_OP_JNZ   :
                j_z   ? BMX_OP_JZ    :
                j_cl  ? BMX_OP_LONG_CALL :
                j_lj  ? BMX_OP_LONG_JUMP  : BMX_OP_NONE;

    assign src = fr_rn ? BMX_LOC_RN  :
                 fr_dr ? BMX_LOC_DIR :
                 fr_in ? BMX_LOC_IND :
                 fr_im ? BMX_LOC_IMM : BMX_LOC_A;
    assign dst = to_rn ? BMX_LOC_RN  :
                 to_dr ? BMX_LOC_DIR :
                 to_in ? BMX_LOC_IND : BMX_LOC_A;

    // source byte first, destination second for direct to direct
    assign src_b2 = m_dr_imm;
    assign dst_b2 = m_dr_dr;

    wire three = m_dr_dr | m_dr_imm | j_nb | j_cl | j_lj;
    wire one   = m_a_rn | m_a_ind | m_rn_a | m_in_a | j_ind | ~known;
    wire fast  = to_a | m_rn_a | m_rn_imm | m_dr_a | m_in_a | m_in_imm | ~known;
    assign len = three ? LEN_3 : one ? LEN_1 : LEN_2;
    assign cyc = fast ? CYC_1 : CYC_2;
endmodule // bmx_decode

// file: rtl/bmx_exec.sv
// How it works
// - indirect jump loads pc with accumulator plus data pointer, sources kept.
// - bit-clear jump adds three, then the signed third byte when bit is zero.
// - carry-clear jump adds two, then the signed second byte when carry is zero.
// - accumulator-nonzero jump adds two, branches when any accumulator bit is one.
// - accumulator-zero jump adds two, branches when accumulator is all zero.
// - long call pushes pc plus three, low byte then high, stack pointer plus two.
// - long call then loads pc high from byte two, low from byte three.
// - long jump loads pc from bytes two and three, pushes nothing.
// - byte move copies source to destination, nothing else changes.
// - fifteen source and destination combinations of the byte move are decoded.
// - moving accumulator to itself by direct address reads the accumulator and leaves it unchanged.
// - moves into accumulator from register, direct, indirect and immediate.
// - moves into working register from accumulator, direct and immediate.
// - moves into direct address from accumulator, register, direct, indirect and immediate.
`timescale 1ns/100ps
module bmx_exec #(
    parameter logic [15:0] RESET_PC = bmx_pkg::PC_RST,
    parameter int          PC_WIDTH = bmx_pkg::PC_W
) (
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      rst,
    // program memory
    output logic [bmx_pkg::PC_W-1:0]       code_addr,
    output logic                           code_rd,
    input  wire logic [bmx_pkg::DW-1:0]    code_data,
    // internal data ram
    output logic [bmx_pkg::DW-1:0]         ram_addr,
    output logic                           ram_rd,
    output logic                           ram_wr,
    output logic [bmx_pkg::DW-1:0]         ram_wdata,
    input  wire logic [bmx_pkg::DW-1:0]    ram_rdata,
    // bit space
    output logic [bmx_pkg::DW-1:0]         bit_addr,
    output logic                           bit_rd,
    input  wire logic                      bit_value,
    // core state in
    input  wire logic [bmx_pkg::PC_W-1:0]  data_pointer,
    input  wire logic                      carry,
    input  wire logic [1:0]                reg_bank,
    // core state out
    output logic [bmx_pkg::PC_W-1:0]       program_counter,
    output logic [bmx_pkg::DW-1:0]         stack_pointer,
    output logic [bmx_pkg::DW-1:0]         accumulator_sfr,
    // status
    output logic                           instr_done,
    output logic [1:0]                     instr_mcycles,
    output logic                           unknown_op
);
    import bmx_pkg::*;

    if (PC_WIDTH != PC_W) begin : g_chk
        $error("bmx_exec serves a 16-bit program counter only");
    end

    typedef enum logic [2:0] {
        S_ISSUE, S_WAIT, S_LATCH, S_RD, S_RDW, S_RDL, S_EXE, S_PUSH
    } bmx_st_e;

    bmx_st_e           st_r;
    logic [15:0]       pc_r;
    logic [7:0]        sp_r;
    logic [7:0]        acc_r;
    logic [7:0]        ib_r [0:2];
    logic [1:0]        idx_r;
    logic [NEED_N-1:0] need_r;
    logic [7:0]        sptr_r;
    logic [7:0]        dind_r;
    logic [7:0]        src_r;
    logic              bit_r;
    logic [15:0]       code_addr_r;
    logic              code_rd_r;
    logic [7:0]        ram_addr_r;
    logic              ram_rd_r;
    logic              ram_wr_r;
    logic [7:0]        ram_wdata_r;
    logic [7:0]        bit_addr_r;
    logic              bit_rd_r;
    logic              done_r;
    logic [1:0]        mcyc_r;
    logic              unk_r;

    bmx_op_e           op_w;
    bmx_loc_e          src_w;
    bmx_loc_e          dst_w;
    logic              src_b2_w;
    logic              dst_b2_w;
    logic [1:0]        len_w;
    logic [1:0]        cyc_w;

    // opcode straight from memory while the first byte lands
    wire [7:0] opc_w = (st_r == S_LATCH && idx_r == IX_OP) ? code_data : ib_r[IX_OP];

    bmx_decode u_dec (
        .opc    (opc_w),
        .op     (op_w),
        .src    (src_w),
        .dst    (dst_w),
        .src_b2 (src_b2_w),
        .dst_b2 (dst_b2_w),
        .len    (len_w),
        .cyc    (cyc_w)
    );

    // operand addressing
    wire [7:0] rn_addr  = {RN_PAGE, reg_bank, opc_w[2:0]};
    wire [7:0] ri_addr  = {RN_PAGE, reg_bank, RI_PAD, opc_w[0]};
    wire [7:0] srcb     = src_b2_w ? ib_r[IX_B2] : ib_r[IX_B1];
    wire [7:0] dstb     = dst_b2_w ? ib_r[IX_B2] : ib_r[IX_B1];
    wire [7:0] src_rd   = src_w == BMX_LOC_RN  ? rn_addr :
                          src_w == BMX_LOC_DIR ? srcb    : sptr_r;
    wire [7:0] dst_addr = dst_w == BMX_LOC_RN  ? rn_addr :
                          dst_w == BMX_LOC_DIR ? dstb    : dind_r;
    wire       to_acc   = dst_w == BMX_LOC_A ||
                          (dst_w == BMX_LOC_DIR && dstb == ACC_DIR);
    wire [7:0] mv_val   = src_w == BMX_LOC_A   ? acc_r :
                          src_w == BMX_LOC_IMM ? srcb  : src_r;
    // a direct source naming the accumulator reads the accumulator itself
    wire       src_acc  = src_w == BMX_LOC_DIR && srcb == ACC_DIR;
    wire [7:0] src_in   = src_acc ? acc_r : ram_rdata;

    // pending reads, lowest bit first
    wire [NEED_N-1:0] need_ini;
    wire              mv_w = op_w == BMX_OP_MOVE;
    assign need_ini[NEED_SP]  = mv_w && src_w == BMX_LOC_IND;
    assign need_ini[NEED_SRC] = mv_w && src_w != BMX_LOC_A && src_w != BMX_LOC_IMM;
    assign need_ini[NEED_DP]  = mv_w && dst_w == BMX_LOC_IND;
    assign need_ini[NEED_BIT] = op_w == BMX_OP_JNB;
    wire [NEED_N-1:0] pick_oh   = need_r & (~need_r + 1'b1);
    wire [NEED_N-1:0] need_left = need_r & ~pick_oh;
    wire              ram_pick  = |pick_oh[NEED_DP:NEED_SP];
    wire [7:0]        rd_addr   = pick_oh[NEED_SRC] ? src_rd : ri_addr;
    wire              more_b    = (idx_r + IX_STEP) < len_w;

    // branch arithmetic
    wire [7:0]  rel    = op_w == BMX_OP_JNB ? ib_r[IX_B2] : ib_r[IX_B1];
    wire [15:0] pc_rel = pc_r + {{8{rel[7]}}, rel};
    wire        take   = op_w == BMX_OP_JNB ? !bit_r  :
                         op_w == BMX_OP_JNC ? !carry  :
                         op_w == BMX_OP_JNZ ? |acc_r  :
                         op_w == BMX_OP_JZ  ? acc_r == ACC_RST : 1'b0;
    wire [15:0] tgt    = {ib_r[IX_B1], ib_r[IX_B2]};
    wire [15:0] ind_pc = {ACC_PAD, acc_r} + data_pointer;
    wire [7:0]  sp_inc = sp_r + SP_STEP;
    wire [7:0]  pc_lo  = pc_r[7:0];
    wire [7:0]  pc_hi  = pc_r[15:8];
    wire        ex_w   = st_r == S_EXE;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r        <= S_ISSUE;
            pc_r        <= RESET_PC;
            sp_r        <= SP_RST;
            acc_r       <= ACC_RST;
            ib_r        <= '{BYTE_0, BYTE_0, BYTE_0};
            idx_r       <= IX_OP;
            need_r      <= '0;
            sptr_r      <= BYTE_0;
            dind_r      <= BYTE_0;
            src_r       <= BYTE_0;
            bit_r       <= 1'b0;
            code_addr_r <= RESET_PC;
            code_rd_r   <= 1'b0;
            ram_addr_r  <= BYTE_0;
            ram_rd_r    <= 1'b0;
            ram_wr_r    <= 1'b0;
            ram_wdata_r <= BYTE_0;
            bit_addr_r  <= BYTE_0;
            bit_rd_r    <= 1'b0;
            done_r      <= 1'b0;
            mcyc_r      <= CYC_1;
            unk_r       <= 1'b0;
        end else begin
            code_rd_r <= 1'b0;
            ram_rd_r  <= 1'b0;
            ram_wr_r  <= 1'b0;
            bit_rd_r  <= 1'b0;
            done_r    <= 1'b0;
            unk_r     <= 1'b0;
            unique case (st_r)
                S_ISSUE: begin
                    code_addr_r <= pc_r;
                    code_rd_r   <= 1'b1;
                    pc_r        <= pc_r + PC_STEP;
                    st_r        <= S_WAIT;
                end
                S_WAIT: st_r <= S_LATCH;
                S_LATCH: begin
                    ib_r[idx_r] <= code_data;
                    if (more_b) begin
                        idx_r <= idx_r + IX_STEP;
                        st_r  <= S_ISSUE;
                    end else begin
                        idx_r  <= IX_OP;
                        need_r <= need_ini;
                        st_r   <= |need_ini ? S_RD : S_EXE;
                    end
                end
                S_RD: begin
                    ram_addr_r <= rd_addr;
                    ram_rd_r   <= ram_pick;
                    bit_addr_r <= ib_r[IX_B1];
                    bit_rd_r   <= !ram_pick;
                    st_r       <= S_RDW;
                end
                S_RDW: st_r <= S_RDL;
                S_RDL: begin
                    if (pick_oh[NEED_SP]) sptr_r <= ram_rdata;
                    if (pick_oh[NEED_SRC]) src_r <= src_in;
                    if (pick_oh[NEED_DP]) dind_r <= ram_rdata;
                    if (pick_oh[NEED_BIT]) bit_r <= bit_value;
                    need_r <= need_left;
                    st_r   <= |need_left ? S_RD : S_EXE;
                end
                S_EXE: begin
                    st_r   <= S_ISSUE;
                    done_r <= 1'b1;
                    mcyc_r <= cyc_w;
                    unique case (op_w)
                        BMX_OP_MOVE: begin
                            if (to_acc) begin
                                acc_r <= mv_val;
                            end else begin
                                ram_wr_r    <= 1'b1;
                                ram_addr_r  <= dst_addr;
                                ram_wdata_r <= mv_val;
                            end
                        end
                        BMX_OP_JMP: pc_r <= ind_pc;
                        BMX_OP_JNB, BMX_OP_JNC, BMX_OP_JNZ, BMX_OP_JZ: begin
                            if (take) pc_r <= pc_rel;
                        end
                        BMX_OP_LONG_JUMP: pc_r <= tgt;
                        BMX_OP_LONG_CALL: begin
                            ram_wr_r    <= 1'b1;
                            ram_addr_r  <= sp_inc;
                            ram_wdata_r <= pc_lo;
                            sp_r        <= sp_inc;
                            done_r      <= 1'b0;
                            st_r        <= S_PUSH;
                        end
                        BMX_OP_NONE: unk_r <= 1'b1;
                    endcase
                end
                S_PUSH: begin
                    ram_wr_r    <= 1'b1;
                    ram_addr_r  <= sp_inc;
                    ram_wdata_r <= pc_hi;
                    sp_r        <= sp_inc;
                    pc_r        <= tgt;
                    done_r      <= 1'b1;
                    st_r        <= S_ISSUE;
                end
            endcase
        end
    end

    assign code_addr       = code_addr_r;
    assign code_rd         = code_rd_r;
    assign ram_addr        = ram_addr_r;
    assign ram_rd          = ram_rd_r;
    assign ram_wr          = ram_wr_r;
    assign ram_wdata       = ram_wdata_r;
    assign bit_addr        = bit_addr_r;
    assign bit_rd          = bit_rd_r;
    assign program_counter = pc_r;
    assign stack_pointer   = sp_r;
    assign accumulator_sfr = acc_r;
    assign instr_done      = done_r;
    assign instr_mcycles   = mcyc_r;
    assign unknown_op      = unk_r;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    logic [15:0] ipc_r;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) ipc_r <= RESET_PC;
        else if (st_r == S_LATCH && idx_r == IX_OP) ipc_r <= code_addr_r;
    end

    jmp_target_a: assert property (ex_w && op_w == BMX_OP_JMP |=>
        pc_r == $past(ind_pc) && acc_r == $past(acc_r))
        else $error("indirect jump target wrong");
    pc_len_a: assert property (ex_w |-> pc_r == ipc_r + {14'h0000, len_w})
        else $error("pc not past the instruction at execute");
    jnb_branch_a: assert property (ex_w && op_w == BMX_OP_JNB |=>
        pc_r == ($past(bit_r) ? $past(pc_r) : $past(pc_rel)))
        else $error("bit-clear jump wrong");
    jnc_branch_a: assert property (ex_w && op_w == BMX_OP_JNC |=>
        pc_r == ($past(carry) ? $past(pc_r) : $past(pc_rel)))
        else $error("carry-clear jump wrong");
    jnz_branch_a: assert property (ex_w && op_w == BMX_OP_JNZ |=>
        pc_r == ($past(acc_r) != ACC_RST ? $past(pc_rel) : $past(pc_r)))
        else $error("nonzero jump wrong");
    jz_branch_a: assert property (ex_w && op_w == BMX_OP_JZ |=>
        pc_r == ($past(acc_r) == ACC_RST ? $past(pc_rel) : $past(pc_r)))
        else $error("zero jump wrong");
    call_push_a: assert property (ex_w && op_w == BMX_OP_LONG_CALL |=>
        (ram_wr && ram_addr == $past(sp_inc) && ram_wdata == $past(pc_lo))
        ##1 (ram_wr && ram_addr == $past(sp_inc) && ram_wdata == $past(pc_hi)))
        else $error("long call push wrong");
    call_target_a: assert property (st_r == S_PUSH |=>
        pc_r == $past(tgt) && sp_r == $past(sp_inc) && instr_done)
        else $error("long call target wrong");
    long_jump_target_a: assert property (ex_w && op_w == BMX_OP_LONG_JUMP |=>
        pc_r == $past(tgt) && $stable(sp_r) && !ram_wr)
        else $error("long jump wrong");
    move_acc_a: assert property (ex_w && mv_w && to_acc |=>
        acc_r == $past(mv_val) && $stable(sp_r) && !ram_wr)
        else $error("move into accumulator wrong");
    move_ram_a: assert property (ex_w && mv_w && !to_acc |=>
        ram_wr && ram_addr == $past(dst_addr) && ram_wdata == $past(mv_val)
        && $stable(acc_r))
        else $error("move into ram wrong");
    dec_form_a: assert property (ex_w && opc_w == OPC_DIR_DIR |->
        len_w == LEN_3 && cyc_w == CYC_2 && src_w == BMX_LOC_DIR)
        else $error("direct to direct decode wrong");
    dec_acc_a: assert property (ex_w && opc_w == OPC_A_IMM |->
        len_w == LEN_2 && cyc_w == CYC_1 && dst_w == BMX_LOC_A)
        else $error("immediate to accumulator decode wrong");
    dec_reg_a: assert property (ex_w && opc_w[7:3] == MV_RN_DIR |->
        len_w == LEN_2 && cyc_w == CYC_2 && dst_w == BMX_LOC_RN)
        else $error("direct to register decode wrong");

    call_seen_c: cover property (st_r == S_PUSH ##1 instr_done);
    jnb_taken_c: cover property (ex_w && op_w == BMX_OP_JNB && !bit_r);
    dir_move_c: cover property (ex_w && opc_w == OPC_DIR_DIR);
    ind_move_c: cover property (ex_w && mv_w && dst_w == BMX_LOC_IND);
endmodule // bmx_exec

// file: testbench/bmx_mem.sv
`timescale 1ns/100ps
module bmx_mem (
    // clock
    input  wire logic        mclk,
    // program memory
    input  wire logic [15:0] code_addr,
    input  wire logic        code_rd,
    output logic      [7:0]  code_data,
    // data ram and bit space
    input  wire logic [7:0]  ram_addr,
    input  wire logic        ram_rd,
    input  wire logic        ram_wr,
    input  wire logic [7:0]  ram_wdata,
    output logic      [7:0]  ram_rdata,
    input  wire logic [7:0]  bit_addr,
    input  wire logic        bit_rd,
    output logic             bit_value
);
    logic [7:0] code [0:65535];
    logic [7:0] ram  [0:255];
    logic       bits [0:255];
    initial begin
        code_data = 8'h00;
        ram_rdata = 8'h00;
        bit_value = 1'b0;
    end
    // answer one cycle after the strobe, scramble otherwise
    always @(posedge mclk) begin
        code_data <= code_rd ? code[code_addr] : ~code_data;
        ram_rdata <= ram_rd ? ram[ram_addr] : ~ram_rdata;
        bit_value <= bit_rd ? bits[bit_addr] : ~bit_value;
        if (ram_wr) begin
            ram[ram_addr] <= ram_wdata;
        end
    end
endmodule // bmx_mem

// file: testbench/branch_and_move_exec_bench.sv
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module branch_and_move_exec_bench;
    import bmx_pkg::*;
    logic mclk = 0, rst = 1, carry = 0, code_rd, ram_rd, ram_wr, bit_rd, bit_value;
    logic instr_done, unknown_op;
    logic [15:0] data_pointer = 16'hffa0, code_addr, program_counter;
    logic [7:0] code_data, ram_addr, ram_wdata, ram_rdata, bit_addr, stack_pointer;
    logic [7:0] accumulator_sfr;
    logic [1:0] reg_bank = 2'h2, instr_mcycles;
    int n_mismatch = 0, checks_done = 0, cycles = 0;
    always #2 mclk = ~mclk;
    bmx_exec bmx_exec_i (.mclk, .rst, .code_addr, .code_rd, .code_data, .ram_addr, .ram_rd,
        .ram_wr, .ram_wdata, .ram_rdata, .bit_addr, .bit_rd, .bit_value, .data_pointer,
        .carry, .reg_bank, .program_counter, .stack_pointer, .accumulator_sfr, .instr_done,
        .instr_mcycles, .unknown_op);
    bmx_mem bmx_mem_i (.mclk, .code_addr, .code_rd, .code_data, .ram_addr, .ram_rd, .ram_wr,
        .ram_wdata, .ram_rdata, .bit_addr, .bit_rd, .bit_value);
    task tally_and_finish;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            tally_and_finish;
        end
    end
    task put(input logic [15:0] a, input logic [7:0] b[]);
        foreach (b[i]) bmx_mem_i.code[a + i] = b[i];
    endtask
    // wait for the finishing pulse, then judge the core state
    task step(input logic [15:0] pc, input logic [7:0] acc, sp, input logic [1:0] mc,
              input logic unk);
        int k;
        k = 0;
        do begin @(posedge mclk); #1; k++; end while (instr_done !== 1'b1 && k < 60);
        `CHK(program_counter, pc)
        `CHK(accumulator_sfr, acc)
        `CHK(stack_pointer, sp)
        `CHK(unknown_op, unk)
        if (!unk) `CHK(instr_mcycles, mc)
    endtask
    task t_branch;
        step(16'h0002, 8'h80, 8'h07, CYC_1, 0);
        step(16'h0014, 8'h80, 8'h07, CYC_2, 0);
        step(16'h0016, 8'h80, 8'h07, CYC_2, 0);
        step(16'h0016, 8'h80, 8'h07, CYC_2, 0);
        @(posedge mclk) carry <= 1'b1;
        step(16'h0018, 8'h80, 8'h07, CYC_2, 0);
        step(16'h000b, 8'h80, 8'h07, CYC_2, 0);
    endtask
    task t_call;
        step(16'h1234, 8'h80, 8'h09, CYC_2, 0);
        step(16'h0040, 8'h80, 8'h09, CYC_2, 0);
        step(16'h0020, 8'h80, 8'h09, CYC_2, 0);
    endtask
    task t_move;
        step(16'h0021, 8'h80, 8'h09, CYC_1, 0);
        step(16'h0023, 8'h5a, 8'h09, CYC_1, 0);
        step(16'h0026, 8'h5a, 8'h09, CYC_2, 0);
        step(16'h0027, 8'hc3, 8'h09, CYC_1, 0);
        step(16'h0029, 8'hc3, 8'h09, CYC_2, 0);
        step(16'h002b, 8'hc3, 8'h09, CYC_2, 0);
        step(16'h002d, 8'hc3, 8'h09, CYC_1, 0);
        step(16'h002f, 8'hc3, 8'h09, CYC_1, 0);
        step(16'h0030, 8'h33, 8'h09, CYC_1, 0);
        step(16'h0031, 8'h33, 8'h09, CYC_1, 0);
        step(16'h0033, 8'h33, 8'h09, CYC_2, 0);
        step(16'h0035, 8'h33, 8'h09, CYC_2, 0);
        step(16'h0037, 8'h33, 8'h09, CYC_1, 0);
        step(16'h003a, 8'h33, 8'h09, CYC_2, 0);
        step(16'h003b, 8'h33, 8'h09, CYC_1, 1);
        repeat (4) @(posedge mclk);
        `CHK(bmx_mem_i.ram[8'h08], 8'h0e)
        `CHK(bmx_mem_i.ram[8'h09], 8'h00)
        `CHK(bmx_mem_i.ram[8'h10], 8'h80)
        `CHK(bmx_mem_i.ram[8'h40], 8'h5a)
        `CHK(bmx_mem_i.ram[8'h11], 8'h5a)
        `CHK(bmx_mem_i.ram[8'h50], 8'h80)
        `CHK(bmx_mem_i.ram[8'h60], 8'hc3)
        `CHK(bmx_mem_i.ram[8'h30], 8'h5a)
        `CHK(bmx_mem_i.ram[8'h12], 8'h33)
        `CHK(bmx_mem_i.ram[8'h70], 8'h33)
        `CHK(bmx_mem_i.ram[8'h80], 8'h5a)
        `CHK(bmx_mem_i.ram[8'h5a], 8'h44)
        `CHK(bmx_mem_i.ram[8'h78], 8'h9c)
    endtask
    initial begin
        put(16'h0000, '{8'h74, 8'h80, 8'h70, 8'h10});
        put(16'h0014, '{8'h60, 8'h05, 8'h50, 8'hfe, 8'h30, 8'h20, 8'hf0});
        put(16'h000b, '{8'h12, 8'h12, 8'h34});
        put(16'h1234, '{8'h02, 8'h00, 8'h40});
        put(16'h0040, '{8'h73});
        put(16'h0020, '{8'hf8, 8'he5, 8'h30, 8'h85, 8'h30, 8'h40, 8'he6, 8'ha9, 8'h40,
                        8'h88, 8'h50, 8'hf5, 8'h60, 8'h7a, 8'h33, 8'hea, 8'hf7,
                        8'h87, 8'h70, 8'ha6, 8'h30, 8'h77, 8'h44, 8'h75, 8'h78,
                        8'h9c, 8'ha5, 8'h02, 8'h00, 8'h3b});
        bmx_mem_i.ram[8'h30] = 8'h5a;
        bmx_mem_i.ram[8'h80] = 8'hc3;
        bmx_mem_i.bits[8'h20] = 1'b0;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        t_branch;
        t_call;
        t_move;
        tally_and_finish;
    end
endmodule // branch_and_move_exec_bench
